/* umpf_pkg.sv */
// Purpose: shared constants and types for the multi-drop serial filter block
// Assumes: 8-bit local register port, one system clock
// Notes:   offsets are register indices on the local port
package umpf_pkg;
  // ==========================================================
  // register map
  localparam logic [2:0] OFF_DATA    = 3'h0;
  localparam logic [2:0] OFF_CSA     = 3'h1;
  localparam logic [2:0] OFF_CSB     = 3'h2;
  localparam logic [2:0] OFF_SHARED  = 3'h3;
  localparam logic [2:0] OFF_BAUDLO  = 3'h4;
  // ==========================================================
  // ctrl_status_a bits
  localparam int CSA_RXC  = 7;
  localparam int CSA_TXC  = 6;
  localparam int CSA_UDRE = 5;
  localparam int CSA_FE   = 4;
  localparam int CSA_DOR  = 3;
  localparam int CSA_PE   = 2;
  localparam int CSA_U2X  = 1;
  localparam int CSA_AFM  = 0;
  // ctrl_status_b bits
  localparam int CSB_RXEN = 4;
  localparam int CSB_TXEN = 3;
  localparam int CSB_SZ2  = 2;
  localparam int CSB_RX9  = 1;
  localparam int CSB_TX9  = 0;
  // frame format bits
  localparam int FMT_SEL  = 7;
  localparam int FMT_TWO  = 3;
  // ==========================================================
  // reset values, and the nine-bit size code
  localparam logic [7:0] FMT_RESET    = 8'h86;
  localparam logic [3:0] BAUDHI_RESET = 4'h0;
  localparam logic [7:0] BAUDLO_RESET = 8'h00;
  localparam logic [2:0] SIZE_NINE    = 3'h7;
  // ==========================================================
  // a received frame from the recovery logic
  typedef struct packed {
    logic [8:0] data;
    logic       stop1;
    logic       frameErr;
    logic       parityErr;
  } umpf_rxframe_t;
  // a frame handed to the transmit shifter
  typedef struct packed {
    logic [8:0] data;
    logic [2:0] sizeCode;
    logic       twoStop;
  } umpf_txframe_t;
endpackage

/* umpf_filter.sv */
// Purpose: decide whether a received frame is kept
// Assumes: frame type read from first stop bit or ninth bit
// Notes:   purely combinational
`timescale 1ns/10ps
module umpf_filter (
  // frame in
  input  wire umpf_pkg::umpf_rxframe_t frame,
  input  wire logic [2:0]              sizeCode,
  input  wire logic                    filterOn,
  // decision
  output logic                         isAddr,
  output logic                         keep
);
  wire nineBit;
  assign nineBit = (sizeCode == umpf_pkg::SIZE_NINE);
  // ninth bit for 9-bit frames, first stop bit otherwise
  assign isAddr = nineBit ? frame.data[8] : frame.stop1;
  assign keep   = !filterOn || isAddr;
endmodule

/* umpf_shared_loc.sv */
// Purpose: access logic for the location shared by baud-high and frame format
// Assumes: one read strobe per cycle at most
// Notes:   read select depends on a read in the previous cycle
`timescale 1ns/10ps
module umpf_shared_loc (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // access
  input  wire logic       wrHit,
  input  wire logic       rdHit,
  input  wire logic [7:0] wrData,
  // contents
  output logic [3:0]      baudHigh,
  output logic [7:0]      frameFmt,
  output logic [7:0]      readVal
);
  logic [3:0] baudHigh_r;
  logic [7:0] frameFmt_r;
  logic       prevRead_r;
  wire        selFmt;
  assign selFmt = wrData[umpf_pkg::FMT_SEL];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      baudHigh_r <= umpf_pkg::BAUDHI_RESET;
      frameFmt_r <= umpf_pkg::FMT_RESET;
      prevRead_r <= 1'b0;
    end else begin
      if (wrHit && !selFmt) baudHigh_r <= wrData[3:0];
      if (wrHit && selFmt) frameFmt_r <= wrData | 8'h80;
      prevRead_r <= rdHit;
    end
  end
  assign baudHigh = baudHigh_r;
  assign frameFmt = frameFmt_r;
  // second back-to-back read sees the format register
  assign readVal  = prevRead_r ? frameFmt_r : {4'h0, baudHigh_r};
endmodule

/* umpf_core.sv */
// Purpose: receive filter, status flags and register access of a serial port
// Assumes: bit recovery and shifting live outside; frames arrive as strobes
// Notes:   receive buffer is two frames deep, as in the port it models
//
// Summary of operation
// - filter on drops every non-address frame
// - 5-8 bit frames: first stop bit types
// - nine-bit frames: ninth bit types frame
// - type one is address, zero is data
// - transmitter ignores the filter bit
// - kept address frame stored, sets receive flag
// - filter off accepts all data frames
// - one size setting for both directions
// - filter bit shares location with tx flag
// - write top bit picks shared target
// - lone read of shared returns baud high
// - back-to-back read returns frame format
// - writing one clears transmit-complete flag
// - filter bit is bit 0, read/write
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module umpf_core (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  // register port
  input  wire logic [2:0]              regAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic [7:0]                   regRdData,
  // receive side from recovery logic
  input  wire logic                    rxValid,
  input  wire umpf_pkg::umpf_rxframe_t rxFrame,
  input  wire logic                    rxStartWhileFull,
  // transmit side to shifter
  output logic                         txLoad,
  output umpf_pkg::umpf_txframe_t      txFrame,
  input  wire logic                    txShiftDone,
  input  wire logic                    txShiftIdle,
  // configuration seen by baud and recovery logic
  output logic [11:0]                  baudDivisor,
  output logic [7:0]                   frameFormat,
  output logic                         doubleSpeed,
  output logic                         rxEnable,
  output logic                         txEnable
);
  // ==========================================================
  // register state
  logic [7:0] csb_r;
  logic       afm_r;
  logic       u2x_r;
  logic       txc_r;
  logic [7:0] baudLo_r;
  logic [7:0] rdData_r;
  logic       txLoad_r;
  umpf_pkg::umpf_txframe_t txFrame_r;
  logic       txPend_r;
  logic [8:0] txBuf_r;
  logic [11:0] baud_r;
  logic [7:0]  fmtOut_r;
  // receive buffer, two entries
  umpf_pkg::umpf_rxframe_t rxMem_r [2];
  logic       rxHead_r;
  logic [1:0] rxCount_r;
  logic       dor_r;
  // ==========================================================
  // decode
  wire wrData   = regWr && (regAddr == umpf_pkg::OFF_DATA);
  wire rdData   = regRd && (regAddr == umpf_pkg::OFF_DATA);
  wire wrCsa    = regWr && (regAddr == umpf_pkg::OFF_CSA);
  wire wrCsb    = regWr && (regAddr == umpf_pkg::OFF_CSB);
  wire wrShared = regWr && (regAddr == umpf_pkg::OFF_SHARED);
  wire rdShared = regRd && (regAddr == umpf_pkg::OFF_SHARED);
  wire wrBaudLo = regWr && (regAddr == umpf_pkg::OFF_BAUDLO);
  // ==========================================================
  // shared location
  logic [3:0] baudHigh;
  logic [7:0] frameFmt;
  logic [7:0] sharedVal;
  umpf_shared_loc uShared (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wrHit    (wrShared),
    .rdHit    (rdShared),
    .wrData   (regWrData),
    .baudHigh (baudHigh),
    .frameFmt (frameFmt),
    .readVal  (sharedVal)
  );
  // one size code for both directions
  wire [2:0] sizeCode = {csb_r[umpf_pkg::CSB_SZ2], frameFmt[2:1]};
  // ==========================================================
  // receive filter
  logic rxIsAddr;
  logic rxKeep;
  umpf_filter uFilter (
    .frame    (rxFrame),
    .sizeCode (sizeCode),
    .filterOn (afm_r),
    .isAddr   (rxIsAddr),
    .keep     (rxKeep)
  );
  wire rxEn    = csb_r[umpf_pkg::CSB_RXEN];
  wire rxFull  = (rxCount_r == 2'd2);
  // dropped frames never reach the buffer
  wire rxPush  = rxValid && rxEn && rxKeep && !rxFull;
  wire rxPop   = rdData && (rxCount_r != 2'd0);
  wire rxTail  = rxHead_r ^ rxCount_r[0];
  umpf_pkg::umpf_rxframe_t rxTop;
  assign rxTop = rxMem_r[rxHead_r];
  wire rxHave  = (rxCount_r != 2'd0);
  // receive-complete follows buffer occupancy like any frame
  wire rxcBit  = rxHave;
  // overrun only counts frames that would have been kept
  wire dorSet  = rxStartWhileFull && rxKeep && rxFull;
  // ==========================================================
  // transmit; the filter bit is not consulted here
  wire txEn    = csb_r[umpf_pkg::CSB_TXEN];
  wire udre    = !txPend_r;
  wire txGo    = txPend_r && txShiftIdle && txEn && !txLoad_r;
  // ==========================================================
  // status read values
  wire [7:0] csaVal = {rxcBit, txc_r, udre, rxHave & rxTop.frameErr, dor_r,
                       rxHave & rxTop.parityErr, u2x_r, afm_r};
  wire [7:0] csbVal = {csb_r[7:2], rxHave & rxTop.data[8], csb_r[umpf_pkg::CSB_TX9]};
  wire [7:0] rdMux  = (regAddr == umpf_pkg::OFF_DATA)   ? (rxHave ? rxTop.data[7:0] : 8'h00) :
                      (regAddr == umpf_pkg::OFF_CSA)    ? csaVal :
                      (regAddr == umpf_pkg::OFF_CSB)    ? csbVal :
                      (regAddr == umpf_pkg::OFF_SHARED) ? sharedVal :
                      (regAddr == umpf_pkg::OFF_BAUDLO) ? baudLo_r : 8'h00;
  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      csb_r    <= 8'h00;
      afm_r    <= 1'b0;
      u2x_r    <= 1'b0;
      baudLo_r <= umpf_pkg::BAUDLO_RESET;
      rdData_r <= 8'h00;
    end else begin
      if (wrCsb) csb_r <= regWrData;
      if (wrCsa) begin
        afm_r <= regWrData[umpf_pkg::CSA_AFM];
        u2x_r <= regWrData[umpf_pkg::CSA_U2X];
      end
      if (wrBaudLo) baudLo_r <= regWrData;
      rdData_r <= regRd ? rdMux : 8'h00;
    end
  end
  // ==========================================================
  // transmit-complete flag: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txc_r <= 1'b0;
    end else if (txShiftDone && !txPend_r) begin
      txc_r <= 1'b1;
    end else if (wrCsa && regWrData[umpf_pkg::CSA_TXC]) begin
      txc_r <= 1'b0;
    end
  end
  // ==========================================================
  // transmit buffer and load strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txPend_r  <= 1'b0;
      txBuf_r   <= 9'h000;
      txLoad_r  <= 1'b0;
      txFrame_r <= '0;
    end else begin
      txLoad_r <= txGo;
      if (txGo) begin
        txFrame_r <= '{data: txBuf_r, sizeCode: sizeCode,
                       twoStop: frameFmt[umpf_pkg::FMT_TWO]};
        txPend_r  <= 1'b0;
      end else if (wrData && udre) begin
        txBuf_r  <= {csb_r[umpf_pkg::CSB_TX9], regWrData};
        txPend_r <= 1'b1;
      end
    end
  end
  // ==========================================================
  // receive buffer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxHead_r  <= 1'b0;
      rxCount_r <= 2'd0;
      dor_r     <= 1'b0;
    end else if (!rxEn) begin
      rxCount_r <= 2'd0;
      dor_r     <= 1'b0;
    end else begin
      if (rxPop) rxHead_r <= !rxHead_r;
      unique case ({rxPush, rxPop})
        2'b10:   rxCount_r <= rxCount_r + 2'd1;
        2'b01:   rxCount_r <= rxCount_r - 2'd1;
        default: rxCount_r <= rxCount_r;
      endcase
      if (dorSet) dor_r <= 1'b1;
      else if (rxPop) dor_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rxPush) rxMem_r[rxTail] <= rxFrame;
  end
  // ==========================================================
  // configuration outputs, registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_r   <= 12'h000;
      fmtOut_r <= umpf_pkg::FMT_RESET;
    end else begin
      baud_r   <= {baudHigh, baudLo_r};
      fmtOut_r <= frameFmt;
    end
  end
  assign regRdData   = rdData_r;
  assign txLoad      = txLoad_r;
  assign txFrame     = txFrame_r;
  assign baudDivisor = baud_r;
  assign frameFormat = fmtOut_r;
  assign doubleSpeed = u2x_r;
  assign rxEnable    = csb_r[umpf_pkg::CSB_RXEN];
  assign txEnable    = csb_r[umpf_pkg::CSB_TXEN];
endmodule

/* umpf_core_monitor.sv */
// Purpose: port checks for the shared location and size sharing
// Assumes: one clock, reset_n async active low
// Notes:   register outputs trail the register state by one cycle
`timescale 1ns/10ps
module umpf_core_monitor (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  // register port
  input wire logic [2:0]              regAddr,
  input wire logic [7:0]              regWrData,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire logic [7:0]              regRdData,
  // transmit and configuration
  input wire logic                    txLoad,
  input wire umpf_pkg::umpf_txframe_t txFrame,
  input wire logic [11:0]             baudDivisor,
  input wire logic [7:0]              frameFormat
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // shared location decode
  wire shRd = regRd && regAddr == umpf_pkg::OFF_SHARED;
  wire shWr = regWr && regAddr == umpf_pkg::OFF_SHARED;
  // ==========================================
  // checks
  a_idle_rd_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero");
  a_lone_rd_baud: assert property (shRd && !$past(shRd) |=>
    regRdData == {4'h0, baudDivisor[11:8]}) else $error("lone shared read wrong");
  a_pair_rd_fmt: assert property (shRd && $past(shRd) |=>
    regRdData == frameFormat) else $error("paired shared read wrong");
  a_wr_baud_high: assert property (shWr && !regWrData[7] |-> ##2
    baudDivisor[11:8] == $past(regWrData[3:0], 2)) else $error("baud high not written");
  a_wr_fmt_sel: assert property (shWr && regWrData[7] |-> ##2
    frameFormat == $past(regWrData, 2)) else $error("format not written");
  // only the cycle this write reaches the output; earlier writes may still land
  a_fmt_keeps_baud: assert property (shWr && regWrData[7] |=> ##1
    $stable(baudDivisor[11:8])) else $error("format write hit baud");
  a_baud_keeps_fmt: assert property (shWr && !regWrData[7] |=> ##1
    $stable(frameFormat)) else $error("baud write hit format");
  a_tx_size_share: assert property (txLoad |->
    txFrame.sizeCode[1:0] == frameFormat[2:1]) else $error("tx size differs");
endmodule
bind umpf_core umpf_core_monitor mon_u (.sys_clk(sys_clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .txLoad(txLoad), .txFrame(txFrame),
  .baudDivisor(baudDivisor), .frameFormat(frameFormat));

/* umpf_peer_model.sv */
// Purpose: far side: bus master frames and transmit shifter
// Assumes: frames arrive whole from bit recovery
// Notes:   no baud timing; shift time kept short
`timescale 1ns/10ps
module umpf_peer_model #(
  parameter int SHIFT_CYC = 6
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  // frames from the bus master
  output logic                        rxValid,
  output umpf_pkg::umpf_rxframe_t     rxFrame,
  output logic                        rxStartWhileFull,
  // transmit shifter
  input wire logic                    txLoad,
  input wire umpf_pkg::umpf_txframe_t txFrame,
  output logic                        txShiftDone,
  output logic                        txShiftIdle
);
  logic [8:0] lastTx_r;
  logic [3:0] busyCnt_r;
  logic       txSeen_r;
  initial begin
    rxValid          = 1'b0;
    rxStartWhileFull = 1'b0;
    rxFrame          = '0;
  end
  // ==========================================
  // master: caller sets the type bit per frame size
  // ovr: frame starts while the buffer is full instead of completing
  task automatic send(input logic [8:0] d, input logic s1, input logic ovr);
    @(posedge sys_clk);
    rxValid          <= !ovr;
    rxStartWhileFull <= ovr;
    rxFrame          <= {d, s1, !s1, 1'b0};
    @(posedge sys_clk);
    rxValid          <= 1'b0;
    rxStartWhileFull <= 1'b0;
    // inverted after release so stale data never passes
    rxFrame <= ~{d, s1, !s1, 1'b0};
  endtask
  // ==========================================
  // shifter: busy a few cycles, then one done pulse
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busyCnt_r   <= 4'h0;
      txShiftIdle <= 1'b1;
      txShiftDone <= 1'b0;
      txSeen_r    <= 1'b0;
      lastTx_r    <= 9'h000;
    end else begin
      txShiftDone <= (busyCnt_r == 4'h1);
      txSeen_r    <= txSeen_r | (busyCnt_r == 4'h1);
      if (txLoad) begin
        busyCnt_r   <= SHIFT_CYC[3:0];
        txShiftIdle <= 1'b0;
        lastTx_r    <= txFrame.data;
      end else if (busyCnt_r != 4'h0) begin
        busyCnt_r   <= busyCnt_r - 4'h1;
        txShiftIdle <= (busyCnt_r == 4'h1);
      end
    end
  end
endmodule

/* umpf_core_tb.sv */
// Purpose: self-checking bench for the serial filter core
// Assumes: peer model plays bus master and shifter
// Notes:   read data checked only in the cycle after the strobe
`timescale 1ns/10ps
module umpf_core_tb;
  logic                    sys_clk;
  logic                    reset_n;
  logic [2:0]              regAddr;
  logic [7:0]              regWrData;
  logic                    regWr;
  logic                    regRd;
  logic [7:0]              regRdData;
  logic                    rxValid;
  umpf_pkg::umpf_rxframe_t rxFrame;
  logic                    txLoad;
  umpf_pkg::umpf_txframe_t txFrame;
  logic                    txShiftDone;
  logic                    txShiftIdle;
  logic [11:0]             baudDivisor;
  logic [7:0]              frameFormat;
  logic                    rxStartWhileFull;
  logic                    doubleSpeed;
  logic                    rxEnable;
  logic                    txEnable;
  logic [12:0]             row;
  int                      fail_count;
  int                      check_count;
  // {nine bits, filter on, frame data, first stop, kept}
  localparam logic [12:0] ROWS [8] = '{
    {2'b00, 9'h055, 2'b11},
    {2'b01, 9'h0A1, 2'b00},
    {2'b01, 9'h1A2, 2'b00},
    {2'b01, 9'h0A3, 2'b11},
    {2'b11, 9'h1B4, 2'b11},
    {2'b11, 9'h0B5, 2'b10},
    {2'b10, 9'h0B6, 2'b11},
    {2'b10, 9'h1B7, 2'b11}
  };
  umpf_core dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxValid(rxValid), .rxFrame(rxFrame), .rxStartWhileFull(rxStartWhileFull),
    .txLoad(txLoad), .txFrame(txFrame), .txShiftDone(txShiftDone),
    .txShiftIdle(txShiftIdle), .baudDivisor(baudDivisor), .frameFormat(frameFormat),
    .doubleSpeed(doubleSpeed), .rxEnable(rxEnable), .txEnable(txEnable));
  umpf_peer_model peer_u (.sys_clk(sys_clk), .reset_n(reset_n), .rxValid(rxValid),
    .rxFrame(rxFrame), .rxStartWhileFull(rxStartWhileFull), .txLoad(txLoad),
    .txFrame(txFrame), .txShiftDone(txShiftDone), .txShiftIdle(txShiftIdle));
  // ==========================================
  // tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // up to three reads with no gap, first address leftmost
  task automatic rds(input int n, input logic [8:0] a, input logic [23:0] e);
    for (int i = 0; i <= n; i++) begin
      @(posedge sys_clk);
      regRd <= (i < n);
      if (i < n) regAddr <= a[8-3*i -: 3];
      if (i > 0) begin
        #1;
        chk(regRdData, e[31-8*i -: 8]);
      end
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    reset_n   = 1'b0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = 3'h0;
    regWrData = 8'h00;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk(frameFormat, 8'h86);
    rds(3, {3{umpf_pkg::OFF_SHARED}}, {8'h00, 8'h86, 8'h86});
    for (int i = 0; i < 8; i++) begin
      row = ROWS[i];
      wr(umpf_pkg::OFF_CSB, {5'h03, row[12], 2'b00});
      wr(umpf_pkg::OFF_CSA, {7'h00, row[11]});
      peer_u.send(row[10:2], row[1], 1'b0);
      repeat (2) @(posedge sys_clk);
      rds(row[0] ? 3 : 1, {umpf_pkg::OFF_CSA, umpf_pkg::OFF_CSB, umpf_pkg::OFF_DATA},
        {row[0], 2'b01, 4'h0, row[11], 5'h03, row[12], row[10], 1'b0, row[9:2]});
    end
    wr(umpf_pkg::OFF_SHARED, 8'h05);
    wr(umpf_pkg::OFF_SHARED, 8'h8E);
    wr(umpf_pkg::OFF_BAUDLO, 8'h34);
    wr(3'h7, 8'hFF);
    repeat (2) @(posedge sys_clk);
    chk(baudDivisor, 12'h534);
    chk(frameFormat, 8'h8E);
    rds(3, {umpf_pkg::OFF_SHARED, umpf_pkg::OFF_CSA, umpf_pkg::OFF_SHARED},
      {8'h05, 8'h20, 8'h05});
    rds(3, {umpf_pkg::OFF_SHARED, umpf_pkg::OFF_SHARED, 3'h7}, {8'h05, 8'h8E, 8'h00});
    wr(umpf_pkg::OFF_CSB, 8'h1D);
    wr(umpf_pkg::OFF_CSA, 8'h01);
    wr(umpf_pkg::OFF_DATA, 8'h3C);
    for (int k = 0; k < 100 && peer_u.txSeen_r !== 1'b1; k++) @(posedge sys_clk);
    if (peer_u.txSeen_r !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    @(posedge sys_clk);
    chk(peer_u.lastTx_r, 9'h13C);
    chk(txFrame.sizeCode, 3'h7);
    chk(txFrame.twoStop, 1'b1);
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'h61, 16'h0000});
    wr(umpf_pkg::OFF_CSA, 8'h40);
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'h20, 16'h0000});
    // ==========================================
    // overrun counts only frames the filter would keep
    wr(umpf_pkg::OFF_CSA, 8'h03);
    peer_u.send(9'h1C1, 1'b1, 1'b0);
    peer_u.send(9'h1C2, 1'b1, 1'b0);
    peer_u.send(9'h0C3, 1'b1, 1'b1);
    chk({doubleSpeed, rxEnable, txEnable}, 3'h7);
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'hA3, 16'h0000});
    peer_u.send(9'h1C4, 1'b1, 1'b1);
    rds(3, {umpf_pkg::OFF_CSA, umpf_pkg::OFF_CSB, umpf_pkg::OFF_DATA},
      {8'hAB, 8'h1F, 8'hC1});
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'hA3, 16'h0000});
    // receiver off flushes the buffer
    wr(umpf_pkg::OFF_CSB, 8'h0D);
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'h23, 16'h0000});
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk(frameFormat, 8'h86);
    chk(baudDivisor, 12'h000);
    chk({doubleSpeed, rxEnable, txEnable}, 3'h0);
    rds(1, {umpf_pkg::OFF_CSA, 6'h00}, {8'h20, 16'h0000});
    wrap_up();
  end
endmodule
